/* File: hw/ticap_pkg.sv */
// shared constants, types and helpers of the free-running timer and the
// input capture block; assumes a 100 MHz hclk and a 32-bit AHB-Lite bus
package ticap_pkg;

  localparam int unsigned TB_W = 16;
  localparam int unsigned N_CH = 4;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned PRE_W = 4;

  // register byte offsets
  localparam logic [7:0] OFS_TCTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_CMP0 = 8'h08;
  localparam logic [7:0] OFS_CPL = 8'h0c;
  localparam logic [7:0] OFS_CPH = 8'h10;
  localparam logic [7:0] OFS_CAP0 = 8'h14;
  localparam logic [7:0] OFS_CAP1 = 8'h18;
  localparam logic [7:0] OFS_CAP2 = 8'h1c;
  localparam logic [7:0] OFS_CAP3 = 8'h20;
  localparam logic [7:0] OFS_STAT = 8'h24;
  localparam logic [7:0] OFS_MASK = 8'h28;

  // timer control fields
  localparam int unsigned TC_SEL_LSB = 0;
  localparam int unsigned TC_CLR_BIT = 2;
  // capture control pair fields (low channel of the pair; high = +2 for edge, +1 for ie and flag)
  localparam int unsigned CP_EDGE_LSB = 0;
  localparam int unsigned CP_IE_LSB = 4;
  localparam int unsigned CP_FLAG_LSB = 6;
  // status / mask fields
  localparam int unsigned ST_OVF = 0;
  localparam int unsigned ST_CAP_LSB = 1;
  localparam int unsigned ST_W = 5;

  // reset values
  localparam logic [1:0] CLK_SEL_RST = 2'h0;
  localparam logic CLR_MODE_RST = 1'b0;
  localparam logic [15:0] CMP0_RST = 16'hffff;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [4:0] MASK_RST = 5'h00;

  typedef enum logic [1:0] {
    EDGE_OFF = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_e;

  // count clock select n gives a tick every 2^(n+1) hclk cycles
  function automatic logic [PRE_W-1:0] div_mask(input logic [1:0] sel);
    unique case (sel)
      2'h0: div_mask = 4'h1;
      2'h1: div_mask = 4'h3;
      2'h2: div_mask = 4'h7;
      2'h3: div_mask = 4'hf;
    endcase
  endfunction

  function automatic logic edge_hit(input edge_e m, input logic prev,
                                    input logic cur);
    unique case (m)
      EDGE_OFF: edge_hit = 1'b0;
      EDGE_RISE: edge_hit = !prev && cur;
      EDGE_FALL: edge_hit = prev && !cur;
      EDGE_BOTH: edge_hit = prev != cur;
    endcase
  endfunction

endpackage

/* File: hw/ticap_if.sv */
// signals between the register block, the time base and the capture bank;
// assumes all three run on the same hclk
`timescale 1ns/1ns
`default_nettype none
interface ticap_if;
  import ticap_pkg::*;
  logic [1:0] clk_sel;
  logic clear_mode;
  logic [15:0] cmp0;
  logic [15:0] time_base;
  logic ovf;
  logic [7:0] edge_sel;
  logic [3:0] hit;
  logic [63:0] cap_word;
  modport base (input clk_sel, clear_mode, cmp0, output time_base, ovf);
  modport bank (input time_base, edge_sel, output hit, cap_word);
  modport ctrl (input time_base, ovf, hit, cap_word,
                output clk_sel, clear_mode, cmp0, edge_sel);
endinterface
`default_nettype wire

/* File: hw/time_base.sv */
// 16-bit free-running up counter with prescaled count clock and
// compare-clear mode; assumes hclk as its only clock
`timescale 1ns/1ns
`default_nettype none
module time_base (
  input wire logic hclk,
  input wire logic hresetn,
  ticap_if.base tb
);
  import ticap_pkg::*;

  logic [PRE_W-1:0] pre;
  logic tick;
  logic [15:0] count;
  logic match;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre <= '0;
    end else begin
      pre <= pre + 4'h1;
    end
  end

  // one-cycle enable at the selected count rate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick <= 1'b0;
    end else begin
      tick <= (pre & div_mask(tb.clk_sel)) == div_mask(tb.clk_sel);
    end
  end

  assign match = tb.clear_mode && (count == tb.cmp0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= COUNT_RST;
    end else if (tick) begin
      if (match) begin
        count <= COUNT_RST;
      end else begin
        count <= count + 16'h0001;
      end
    end
  end

  // overflow only on a true wrap, not on a compare clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tb.ovf <= 1'b0;
    end else begin
      tb.ovf <= tick && !match && (count == 16'hffff);
    end
  end

  assign tb.time_base = count;

  AST_WRAP: assert property (@(posedge hclk) disable iff (!hresetn)
    tick && !match && count == 16'hffff |=> count == 16'h0000 && tb.ovf)
    else $error("counter did not wrap with overflow");
  AST_INC: assert property (@(posedge hclk) disable iff (!hresetn)
    tick && !match |=> count == $past(count) + 16'h0001)
    else $error("counter did not increment on tick");
  AST_STILL: assert property (@(posedge hclk) disable iff (!hresetn)
    !tick |=> $stable(count))
    else $error("counter moved without a tick");
  AST_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    tick && tb.clear_mode && count == tb.cmp0 |=> count == 16'h0000
    && !tb.ovf)
    else $error("compare clear failed");
endmodule
`default_nettype wire

/* File: hw/capture_bank.sv */
// four input capture channels, each with its own synchronised pin;
// assumes pins are asynchronous to hclk
`timescale 1ns/1ns
`default_nettype none
module capture_bank #(
  parameter int unsigned CH = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [CH-1:0] cap_pin,
  ticap_if.bank cb
);
  import ticap_pkg::*;

  logic [CH-1:0] meta;
  logic [CH-1:0] sync;
  logic [CH-1:0] prev;

  // first stage feeds only the second; edges seen between sync and prev
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
    end else begin
      meta <= cap_pin;
      sync <= meta;
      prev <= sync;
    end
  end

  logic [CH-1:0] hit_now;

  always_comb begin
    for (int i = 0; i < CH; i++) begin
      hit_now[i] = edge_hit(edge_e'(cb.edge_sel[2*i +: 2]), prev[i],
                            sync[i]);
    end
  end

  // one process owns all channels so hit and cap_word keep one driver
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cb.hit <= '0;
      cb.cap_word <= '0;
    end else begin
      cb.hit <= hit_now;
      for (int i = 0; i < CH; i++) begin
        if (hit_now[i]) begin
          cb.cap_word[16*i +: 16] <= cb.time_base;
        end
      end
    end
  end

  for (genvar i = 0; i < CH; i++) begin : g_ch
    AST_CAPVAL: assert property (@(posedge hclk) disable iff (!hresetn)
      hit_now[i] |=> cb.hit[i] &&
      cb.cap_word[16*i +: 16] == $past(cb.time_base))
      else $error("capture value not latched");
    AST_NOEDGE: assert property (@(posedge hclk) disable iff (!hresetn)
      cb.edge_sel[2*i +: 2] == 2'b00 && $past(cb.edge_sel[2*i +: 2]) == 2'b00
      |-> !cb.hit[i])
      else $error("capture while detection off");
    AST_RISE: assert property (@(posedge hclk) disable iff (!hresetn)
      cb.edge_sel[2*i +: 2] == 2'b01 && !prev[i] && sync[i] |=> cb.hit[i])
      else $error("rising edge missed");
  end
endmodule
`default_nettype wire

/* File: hw/ticap_top.sv */
// AHB-Lite slave for the free-running timer and four input captures;
// assumes one hclk domain, single word transfers, async active-low reset
`timescale 1ns/1ns
`default_nettype none
module ticap_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [ticap_pkg::N_CH-1:0] cap_pin,
  output logic [15:0] time_base_out,
  output logic irq
);
  import ticap_pkg::*;

  ticap_if bus_i ();

  time_base u_base (
    .hclk(hclk),
    .hresetn(hresetn),
    .tb(bus_i.base)
  );

  capture_bank #(.CH(N_CH)) u_bank (
    .hclk(hclk),
    .hresetn(hresetn),
    .cap_pin(cap_pin),
    .cb(bus_i.bank)
  );

  // software-visible state
  logic [1:0] clk_sel;
  logic clear_mode;
  logic [15:0] cmp0;
  logic [7:0] edge_sel;
  logic [3:0] cap_ie;
  logic [3:0] cap_flag;
  logic [ST_W-1:0] stat;
  logic [ST_W-1:0] mask;

  assign bus_i.clk_sel = clk_sel;
  assign bus_i.clear_mode = clear_mode;
  assign bus_i.cmp0 = cmp0;
  assign bus_i.edge_sel = edge_sel;

  // bus phase tracking
  logic accept;
  logic wr_pend;
  logic rd_pend;
  logic [ADDR_W-1:0] ph_addr;
  logic wr_en;
  logic [31:0] wdat;

  assign accept = hsel && htrans[1] && hready;
  assign wr_en = wr_pend;
  assign wdat = hwdata;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      ph_addr <= '0;
    end else begin
      wr_pend <= accept && hwrite;
      rd_pend <= accept && !hwrite;
      if (accept) begin
        ph_addr <= haddr[ADDR_W-1:0];
      end
    end
  end

  // reads take one wait state so a write just before is already visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= !(accept && !hwrite);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  function automatic logic [7:0] pair_byte(input logic [1:0] flg,
                                           input logic [1:0] ie,
                                           input logic [3:0] edg);
    pair_byte = {flg[1], flg[0], ie[1], ie[0], edg};
  endfunction

  function automatic logic [31:0] rd_word(input logic [ADDR_W-1:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      OFS_TCTRL: w = {29'h0, clear_mode, clk_sel};
      OFS_COUNT: w = {16'h0, bus_i.time_base};
      OFS_CMP0: w = {16'h0, cmp0};
      OFS_CPL: w = {24'h0, pair_byte(cap_flag[1:0], cap_ie[1:0],
                                     edge_sel[3:0])};
      OFS_CPH: w = {24'h0, pair_byte(cap_flag[3:2], cap_ie[3:2],
                                     edge_sel[7:4])};
      OFS_CAP0: w = {16'h0, bus_i.cap_word[15:0]};
      OFS_CAP1: w = {16'h0, bus_i.cap_word[31:16]};
      OFS_CAP2: w = {16'h0, bus_i.cap_word[47:32]};
      OFS_CAP3: w = {16'h0, bus_i.cap_word[63:48]};
      OFS_STAT: w = {27'h0, stat};
      OFS_MASK: w = {27'h0, mask};
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend) begin
      hrdata <= rd_word(ph_addr);
    end
  end

  // timer control and compare clear 0
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_sel <= CLK_SEL_RST;
      clear_mode <= CLR_MODE_RST;
      cmp0 <= CMP0_RST;
    end else if (wr_en) begin
      if (ph_addr == OFS_TCTRL) begin
        clk_sel <= wdat[TC_SEL_LSB +: 2];
        clear_mode <= wdat[TC_CLR_BIT];
      end
      if (ph_addr == OFS_CMP0) begin
        cmp0 <= wdat[15:0];
      end
    end
  end

  // edge selects and capture interrupt enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edge_sel <= 8'h00;
      cap_ie <= 4'h0;
    end else if (wr_en) begin
      if (ph_addr == OFS_CPL) begin
        edge_sel[3:0] <= wdat[CP_EDGE_LSB +: 4];
        cap_ie[1:0] <= wdat[CP_IE_LSB +: 2];
      end
      if (ph_addr == OFS_CPH) begin
        edge_sel[7:4] <= wdat[CP_EDGE_LSB +: 4];
        cap_ie[3:2] <= wdat[CP_IE_LSB +: 2];
      end
    end
  end

  // capture flags: a zero written clears, a new capture wins over it
  logic [3:0] flag_clr;
  always_comb begin
    flag_clr = 4'h0;
    if (wr_en && ph_addr == OFS_CPL) begin
      flag_clr[1:0] = ~wdat[CP_FLAG_LSB +: 2];
    end
    if (wr_en && ph_addr == OFS_CPH) begin
      flag_clr[3:2] = ~wdat[CP_FLAG_LSB +: 2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_flag <= 4'h0;
    end else begin
      cap_flag <= bus_i.hit | (cap_flag & ~flag_clr);
    end
  end

  // sticky event status, write one to clear, set wins
  logic [ST_W-1:0] ev;
  logic [ST_W-1:0] st_clr;
  assign ev = {bus_i.hit, bus_i.ovf};
  assign st_clr = (wr_en && ph_addr == OFS_STAT) ? wdat[ST_W-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat <= '0;
    end else begin
      stat <= ev | (stat & ~st_clr);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask <= MASK_RST;
    end else if (wr_en && ph_addr == OFS_MASK) begin
      mask <= wdat[ST_W-1:0];
    end
  end

  // one cycle behind the flags; keeps the pin glitch free
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (|(stat & mask)) || (|(cap_flag & cap_ie));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      time_base_out <= COUNT_RST;
    end else begin
      time_base_out <= bus_i.time_base;
    end
  end

  AST_OVF_STAT: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_i.ovf |=> stat[ST_OVF])
    else $error("overflow not recorded");
  // the mask that counts is the one seen when the status bit is already set
  AST_OVF_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_i.ovf ##1 mask[ST_OVF] |=> irq)
    else $error("unmasked overflow gave no irq");
  AST_FLAG_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_i.hit != 4'h0 |=> (cap_flag & $past(bus_i.hit)) == $past(bus_i.hit))
    else $error("capture flag lost");
  AST_CAP_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
    (cap_flag & cap_ie) != 4'h0 |=> irq)
    else $error("enabled capture flag gave no irq");
  AST_NO_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
    (stat & mask) == '0 && (cap_flag & cap_ie) == 4'h0 |=> !irq)
    else $error("irq with nothing pending");
  AST_RD_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
    accept && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_TB_OUT: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 time_base_out == $past(bus_i.time_base))
    else $error("time base output out of step");
endmodule
`default_nettype wire

/* File: tb/cap_pin_model.sv */
// external signal sources on the four capture pins
// assumes edges are launched just after a rising hclk edge
`timescale 1ns/1ns
`default_nettype none
module cap_pin_model (
  input wire logic hclk,
  output logic [3:0] cap_pin
);
  initial begin
    cap_pin = 4'h0;
  end

  // each pin moves on its own; held 3 cycles so the synchroniser sees it
  task automatic set_pin(input int ch, input logic v);
    cap_pin[ch] <= v;
    repeat (3) @(posedge hclk);
  endtask
endmodule
`default_nettype wire

/* File: tb/free_run_timer_input_capture_tb.sv */
// self-checking bench for ticap_top: AHB-Lite master tasks, pin model
// assumes the one slave's hreadyout is fed back as hready
`timescale 1ns/1ns
`default_nettype none
module free_run_timer_input_capture_tb;
  import ticap_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, x, old;
  logic [1:0] htrans;
  logic [3:0] cap_pin;
  logic [15:0] tbo, t0, t1, cmp, mx;
  int n_mismatch, checks, seed, r, c;

  ticap_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cap_pin(cap_pin),
    .time_base_out(tbo), .irq(irq));
  cap_pin_model pins (.hclk(hclk), .cap_pin(cap_pin));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // capture may land a few ticks after the reference, wrap-safe
  task automatic chk_near(input logic [31:0] got, input logic [15:0] ref0,
                          input string what);
    logic [15:0] d;
    logic ok;
    d = got[15:0] - ref0;
    ok = (got[31:16] === 16'h0000) && (d <= 16'h0006);
    checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h ref %h", $time, what, got, ref0);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                       input string what);
    logic [31:0] got;
    bus(1'b0, a, 32'h0, got);
    chk(got, exp, what);
    chk({31'h0, hresp}, 32'h0, "response not okay");
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  function automatic logic [7:0] pair_ofs(input int ch);
    return (ch < 2) ? OFS_CPL : OFS_CPH;
  endfunction

  function automatic logic [31:0] pair_val(input int ch, input int m,
                                           input int ie);
    return 32'((m << (2 * (ch % 2))) | (ie << (4 + ch % 2)));
  endfunction

  function automatic logic hits(input int m, input int rising);
    return (m == 3) || (m == 1 && rising == 1) || (m == 2 && rising == 0);
  endfunction

  initial begin
    seed = 47418;
    n_mismatch = 0;
    checks = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    cyc(4);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({31'h0, irq}, 32'h0, "irq after reset");
    rdchk(OFS_TCTRL, 32'h0, "timer ctrl reset");
    rdchk(OFS_CMP0, 32'h0000ffff, "cmp0 reset");
    rdchk(OFS_MASK, 32'h0, "mask reset");
    rdchk(OFS_STAT, 32'h0, "status reset");
    rdchk(8'h2c, 32'h0, "unmapped read");
    wr(8'h2c, 32'hffffffff);
    rdchk(OFS_MASK, 32'h0, "unmapped write leaks");
    done("reset");
    for (int s = 0; s < 4; s++) begin
      wr(OFS_TCTRL, 32'(s));
      cyc(40);
      t0 = tbo;
      cyc(4 << (s + 1));
      t1 = tbo;
      chk(32'(16'(t1 - t0)), 32'h4, "ticks per period");
      bus(1'b0, OFS_COUNT, 32'h0, x);
      chk_near(x, t1, "count register");
    end
    done("count clocks");
    cmp = tbo + 16'h0010 + 16'($random(seed) & 63);
    wr(OFS_CMP0, 32'(cmp));
    wr(OFS_TCTRL, 32'h4);
    mx = 16'h0;
    repeat (2000) begin
      @(posedge hclk);
      if (tbo > mx) mx = tbo;
    end
    chk(32'(mx), 32'(cmp), "clear mode peak");
    wr(OFS_TCTRL, 32'h0);
    rdchk(OFS_STAT, 32'h0, "no overflow on clear");
    done("compare clear");
    r = $random(seed) & 3;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 4; k++) begin
        c = (k + r) % 4;
        wr(pair_ofs(c), pair_val(c, m, 0));
        for (int e = 1; e >= 0; e--) begin
          bus(1'b0, 8'(OFS_CAP0 + 4 * c), 32'h0, old);
          wr(OFS_STAT, 32'h1e);
          cyc(1 + ($random(seed) & 7));
          t0 = tbo;
          pins.set_pin(c, e[0]);
          cyc(4);
          bus(1'b0, 8'(OFS_CAP0 + 4 * c), 32'h0, x);
          if (hits(m, e)) begin
            chk_near(x, t0, "captured value");
          end else begin
            chk(x, old, "ignored edge");
          end
          rdchk(OFS_STAT, hits(m, e) ? 32'(2 << c) : 32'h0, "status");
        end
      end
    end
    done("edge modes");
    c = $random(seed) & 3;
    wr(pair_ofs(c), pair_val(c, 1, 1));
    wr(OFS_STAT, 32'h1f);
    pins.set_pin(c, 1'b1);
    cyc(4);
    chk({31'h0, irq}, 32'h1, "irq on capture");
    rdchk(pair_ofs(c), pair_val(c, 1, 1) | 32'(64 << (c % 2)), "flag");
    wr(pair_ofs(c), pair_val(c, 1, 1));
    cyc(2);
    chk({31'h0, irq}, 32'h0, "irq after flag clear");
    wr(OFS_MASK, 32'(2 << c));
    rdchk(OFS_MASK, 32'(2 << c), "mask readback");
    cyc(2);
    chk({31'h0, irq}, 32'h1, "irq from masked status");
    wr(OFS_STAT, 32'(2 << c));
    cyc(2);
    chk({31'h0, irq}, 32'h0, "irq after status clear");
    wr(OFS_MASK, 32'h0);
    pins.set_pin(c, 1'b0);
    done("interrupts");
    give_verdict();
  end

  // the sequence above needs well under 10000 cycles
  initial begin
    repeat (30000) @(posedge hclk);
    n_mismatch++;
    $display("MISMATCH %0t watchdog expired", $time);
    give_verdict();
  end
endmodule
`default_nettype wire
